// [logic/svc_negotiate.sv]
// How it works
// - fabric login request always carries the QoS bit, word 0 bit 21, set.
// - QoS is usable only when request and accept both carry the bit.
// - four QoS cases decoded; only both-set makes QoS usable.
// - the QoS outcome covers the class 2 and class 3 parameter sets.
// - advertising word 0 bit 11 enables processing of received ACK frames.
// - ACK_0 per direction needs initiator bit 11 and recipient bit 31 both set.
// - negotiated ACK_0 is used instead of ACK_1.
// - initiator and recipient ACK_0 bits are held and resolved separately.
// - setting both bits supports ACK_0 in both roles.
// - recipient ACK_0 advertising means infinite buffering and sending ACK_0 replies; replies here are ACK_0 only when the peer also sets initiator bit 11.
// - word 0 bit 9 reports ACK generation assistance to the recipient.
// - clock-sync bit word 0 bit 4 counts only from address FFFFF6h.
// - X_ID interlock, word 1 bit 29, applies to class 2 only.
// - interlocked first data frame carries recipient X_ID FFFFh.
// - recipient returns its own X_ID in the ACK to the first frame.
// - initiator holds further frames until that ACK, then uses both X_IDs.
//
// Chosen here: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module svc_negotiate
	import svc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [31:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [31:0] rd_data,
	input wire logic login_start,
	input wire logic login_fabric,
	input wire logic logout,
	output logic login_req_valid,
	output logic [31:0] login_c2_w0,
	output logic [31:0] login_c3_w0,
	output logic [31:0] login_w1,
	input wire logic acc_valid,
	input wire logic acc_reject,
	input wire logic [31:0] acc_w0,
	input wire logic [31:0] acc_w1,
	input wire logic [23:0] acc_src_id,
	output logic logged_in,
	output logic qos_usable,
	output logic ack0_as_init,
	output logic ack0_as_recip,
	output logic ack_rx_enable,
	output logic inf_buffering,
	output logic interlock_on,
	output logic peer_ack_assist,
	output logic peer_clksync,
	input wire logic tx_valid,
	input wire logic tx_first,
	input wire logic tx_class2,
	output logic tx_ready,
	output logic tx_fire,
	output logic [15:0] tx_rxid,
	input wire logic ack_in_valid,
	input wire logic [15:0] ack_in_xid,
	input wire logic rx_valid,
	input wire logic rx_first,
	input wire logic rx_last,
	input wire logic rx_class2,
	input wire logic [15:0] rx_rxid,
	output logic ack_out_valid,
	output logic [15:0] ack_out_xid,
	output logic ack_out_ack0
);
	// ==========================================================
	// helpers
	function automatic qos_case_t qos_decode(input logic req, input logic acc);
		qos_case_t c;
		c = qos_case_t'({req, acc});
		return c;
	endfunction

	function automatic logic [31:0] build_w0(input logic valid, input logic [6:0] cfg);
		logic [31:0] w;
		w = 32'h0000_0000;
		w[W0_CLASS_VALID] = valid;
		w[W0_QOS] = 1'b1;
		w[W0_INIT_ACK0] = cfg[CFG_INIT_ACK0];
		w[W0_ACK_ASSIST] = cfg[CFG_ACK_ASSIST];
		w[W0_CLKSYNC] = cfg[CFG_CLKSYNC];
		return w;
	endfunction

	// ==========================================================
	// register slave
	logic [6:0] cfg_reg;
	logic [15:0] xid_reg;
	logic [31:0] rd_data_reg;
	logic [31:0] peer_w0_reg, peer_w1_reg;
	logic [31:0] status_word;
	xid_if fx();

	wire logic hit_cfg = (addr == OFS_CFG);
	wire logic hit_xid = (addr == OFS_XID);
	wire logic hit_status = (addr == OFS_STATUS);
	wire logic hit_pw0 = (addr == OFS_PEER_W0);
	wire logic hit_pw1 = (addr == OFS_PEER_W1);
	wire logic hit_asg = (addr == OFS_ASSIGNED);
	wire logic [31:0] rd_mux = hit_cfg ? {25'h0, cfg_reg} :
		hit_xid ? {16'h0000, xid_reg} :
		hit_status ? status_word :
		hit_pw0 ? peer_w0_reg :
		hit_pw1 ? peer_w1_reg :
		hit_asg ? {16'h0000, fx.assigned_xid} : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= CFG_RESET;
			xid_reg <= XID_RESET;
		end else if (wr_en) begin
			if (hit_cfg) begin
				cfg_reg <= wr_data[6:0];
			end
			if (hit_xid) begin
				xid_reg <= wr_data[15:0];
			end
		end
	end

	// read data stands for the one cycle after the strobe only
	always_ff @(posedge clk) begin
		if (rst) begin
			rd_data_reg <= 32'h0000_0000;
		end else begin
			rd_data_reg <= rd_en ? rd_mux : 32'h0000_0000;
		end
	end
	assign rd_data = rd_data_reg;

	// ==========================================================
	// login sequencing
	login_state_t state_reg, state_next;
	logic req_valid_reg;
	logic req_fabric_reg;
	logic [31:0] req_c2_w0_reg, req_c3_w0_reg, req_w1_reg;
	logic [31:0] req_w1_next;

	always_comb begin
		req_w1_next = 32'h0000_0000;
		req_w1_next[W1_RECIP_ACK0] = cfg_reg[CFG_RECIP_ACK0];
		req_w1_next[W1_XID_IL] = cfg_reg[CFG_XID_IL];
	end

	wire logic start_ok = login_start & (state_reg != LS_WAIT_ACC);
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			LS_IDLE: begin
				if (login_start) begin
					state_next = LS_WAIT_ACC;
				end
			end
			LS_WAIT_ACC: begin
				if (logout || acc_reject) begin
					state_next = LS_IDLE;
				end else if (acc_valid) begin
					state_next = LS_DONE;
				end
			end
			LS_DONE: begin
				if (logout) begin
					state_next = LS_IDLE;
				end else if (login_start) begin
					state_next = LS_WAIT_ACC;
				end
			end
			default: begin
				state_next = LS_IDLE;
			end
		endcase
	end

	// request words are frozen at start so later cfg writes cannot skew the outcome
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= LS_IDLE;
			req_valid_reg <= 1'b0;
			req_fabric_reg <= 1'b0;
			req_c2_w0_reg <= 32'h0000_0000;
			req_c3_w0_reg <= 32'h0000_0000;
			req_w1_reg <= 32'h0000_0000;
		end else begin
			state_reg <= state_next;
			req_valid_reg <= start_ok;
			if (start_ok) begin
				req_fabric_reg <= login_fabric;
				req_c2_w0_reg <= build_w0(cfg_reg[CFG_C2_VALID], cfg_reg);
				req_c3_w0_reg <= build_w0(cfg_reg[CFG_C3_VALID], cfg_reg);
				req_w1_reg <= req_w1_next;
			end
		end
	end
	assign login_req_valid = req_valid_reg;
	assign login_c2_w0 = req_c2_w0_reg;
	assign login_c3_w0 = req_c3_w0_reg;
	assign login_w1 = req_w1_reg;

	// ==========================================================
	// resolution of the accept
	wire logic accept_now = (state_reg == LS_WAIT_ACC) & acc_valid & ~acc_reject & ~logout;
	wire logic clear_now = logout | ((state_reg == LS_WAIT_ACC) & acc_reject);
	wire logic req_qos = req_c2_w0_reg[W0_QOS] | req_c3_w0_reg[W0_QOS];
	wire qos_case_t qos_case_next = qos_decode(req_qos, acc_w0[W0_QOS]);
	wire logic qos_ok_next = (qos_case_next == QOS_AGREED);
	wire logic ack0_init_next = req_c2_w0_reg[W0_INIT_ACK0] & acc_w1[W1_RECIP_ACK0];
	wire logic ack0_recip_next = req_w1_reg[W1_RECIP_ACK0] & acc_w0[W0_INIT_ACK0];
	wire logic c2_both = req_c2_w0_reg[W0_CLASS_VALID] & acc_w0[W0_CLASS_VALID];
	wire logic il_next = c2_both & (req_w1_reg[W1_XID_IL] | acc_w1[W1_XID_IL]);
	wire logic from_clk_server = (acc_src_id == CLKSYNC_SERVER_ID);
	wire logic clksync_next = acc_w0[W0_CLKSYNC] & from_clk_server;

	qos_case_t qos_case_reg;
	logic logged_in_reg, qos_ok_reg, ack0_init_reg, ack0_recip_reg;
	logic il_reg, assist_reg, clksync_reg, ack_rx_en_reg, inf_buf_reg;

	always_ff @(posedge clk) begin
		if (rst) begin
			qos_case_reg <= QOS_NONE;
			logged_in_reg <= 1'b0;
			qos_ok_reg <= 1'b0;
			ack0_init_reg <= 1'b0;
			ack0_recip_reg <= 1'b0;
			il_reg <= 1'b0;
			assist_reg <= 1'b0;
			clksync_reg <= 1'b0;
			ack_rx_en_reg <= 1'b0;
			inf_buf_reg <= 1'b0;
			peer_w0_reg <= 32'h0000_0000;
			peer_w1_reg <= 32'h0000_0000;
		end else if (clear_now) begin
			qos_case_reg <= QOS_NONE;
			logged_in_reg <= 1'b0;
			qos_ok_reg <= 1'b0;
			ack0_init_reg <= 1'b0;
			ack0_recip_reg <= 1'b0;
			il_reg <= 1'b0;
			assist_reg <= 1'b0;
			clksync_reg <= 1'b0;
			ack_rx_en_reg <= 1'b0;
			inf_buf_reg <= 1'b0;
		end else if (accept_now) begin
			qos_case_reg <= qos_case_next;
			logged_in_reg <= 1'b1;
			qos_ok_reg <= qos_ok_next;
			ack0_init_reg <= ack0_init_next;
			ack0_recip_reg <= ack0_recip_next;
			il_reg <= il_next;
			assist_reg <= acc_w0[W0_ACK_ASSIST];
			clksync_reg <= clksync_next;
			ack_rx_en_reg <= req_c2_w0_reg[W0_INIT_ACK0];
			inf_buf_reg <= req_w1_reg[W1_RECIP_ACK0];
			peer_w0_reg <= acc_w0;
			peer_w1_reg <= acc_w1;
		end
	end

	assign logged_in = logged_in_reg;
	assign qos_usable = qos_ok_reg;
	assign ack0_as_init = ack0_init_reg;
	assign ack0_as_recip = ack0_recip_reg;
	assign ack_rx_enable = ack_rx_en_reg;
	assign inf_buffering = inf_buf_reg;
	assign interlock_on = il_reg;
	assign peer_ack_assist = assist_reg;
	assign peer_clksync = clksync_reg;

	// ==========================================================
	// status word
	always_comb begin
		status_word = 32'h0000_0000;
		status_word[ST_QOS_CASE +: 2] = qos_case_reg;
		status_word[ST_QOS_OK] = qos_ok_reg;
		status_word[ST_ACK0_INIT] = ack0_init_reg;
		status_word[ST_ACK0_RECIP] = ack0_recip_reg;
		status_word[ST_IL_ON] = il_reg;
		status_word[ST_PEER_ASSIST] = assist_reg;
		status_word[ST_PEER_CLKSYNC] = clksync_reg;
		status_word[ST_LOGGED_IN] = logged_in_reg;
		status_word[ST_BUSY] = (state_reg == LS_WAIT_ACC);
		status_word[ST_IL_WAIT] = fx.il_wait;
	end

	// ==========================================================
	// frame exchange
	// class 3 frames never reach the interlock: the class2 flags gate it
	assign fx.il_on = il_reg;
	assign fx.ack0_recip = ack0_recip_reg;
	assign fx.own_xid = xid_reg;
	assign fx.tx_valid = tx_valid;
	assign fx.tx_first = tx_first;
	assign fx.tx_class2 = tx_class2;
	assign fx.ack_in_valid = ack_in_valid;
	assign fx.ack_in_xid = ack_in_xid;
	assign fx.rx_valid = rx_valid;
	assign fx.rx_first = rx_first;
	assign fx.rx_last = rx_last;
	assign fx.rx_class2 = rx_class2;
	assign fx.rx_rxid = rx_rxid;

	xid_interlock u_xid (
		.clk(clk),
		.rst(rst),
		.fx(fx)
	);

	assign tx_ready = fx.tx_ready;
	assign tx_fire = fx.tx_fire;
	assign tx_rxid = fx.tx_rxid;
	assign ack_out_valid = fx.ack_out_valid;
	assign ack_out_xid = fx.ack_out_xid;
	assign ack_out_ack0 = fx.ack_out_ack0;
endmodule
`default_nettype wire

// [pkg/svc_pkg.sv]
`default_nettype none
package svc_pkg;
	// ==========================================================
	// service-parameter bit positions
	localparam int W0_CLASS_VALID = 31;
	localparam int W0_QOS = 21;
	localparam int W0_INIT_ACK0 = 11;
	localparam int W0_ACK_ASSIST = 9;
	localparam int W0_CLKSYNC = 4;
	localparam int W1_RECIP_ACK0 = 31;
	localparam int W1_XID_IL = 29;
	localparam logic [15:0] XID_UNASSIGNED = 16'hFFFF;
	localparam logic [23:0] CLKSYNC_SERVER_ID = 24'hFFFFF6;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_CFG = 8'h00;
	localparam logic [7:0] OFS_XID = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_PEER_W0 = 8'h0C;
	localparam logic [7:0] OFS_PEER_W1 = 8'h10;
	localparam logic [7:0] OFS_ASSIGNED = 8'h14;
	// ==========================================================
	// config fields and reset values
	localparam int CFG_INIT_ACK0 = 0;
	localparam int CFG_RECIP_ACK0 = 1;
	localparam int CFG_ACK_ASSIST = 2;
	localparam int CFG_XID_IL = 3;
	localparam int CFG_CLKSYNC = 4;
	localparam int CFG_C2_VALID = 5;
	localparam int CFG_C3_VALID = 6;
	localparam logic [6:0] CFG_RESET = 7'h60;
	localparam logic [15:0] XID_RESET = 16'h0000;
	// ==========================================================
	// status fields
	localparam int ST_QOS_CASE = 0;
	localparam int ST_QOS_OK = 2;
	localparam int ST_ACK0_INIT = 3;
	localparam int ST_ACK0_RECIP = 4;
	localparam int ST_IL_ON = 5;
	localparam int ST_PEER_ASSIST = 6;
	localparam int ST_PEER_CLKSYNC = 7;
	localparam int ST_LOGGED_IN = 8;
	localparam int ST_BUSY = 9;
	localparam int ST_IL_WAIT = 10;
	// ==========================================================
	// state and case encodings
	typedef enum logic [1:0] {
		LS_IDLE = 2'b00,
		LS_WAIT_ACC = 2'b01,
		LS_DONE = 2'b10
	} login_state_t;
	typedef enum logic [1:0] {
		QOS_NONE = 2'b00,
		QOS_FABRIC_ONLY = 2'b01,
		QOS_REFUSED = 2'b10,
		QOS_AGREED = 2'b11
	} qos_case_t;
	typedef enum logic {
		IL_IDLE = 1'b0,
		IL_WAIT = 1'b1
	} il_state_t;
endpackage
`default_nettype wire

// [pkg/xid_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface xid_if;
	logic il_on;
	logic ack0_recip;
	logic [15:0] own_xid;
	logic tx_valid;
	logic tx_first;
	logic tx_class2;
	logic tx_ready;
	logic tx_fire;
	logic [15:0] tx_rxid;
	logic [15:0] assigned_xid;
	logic il_wait;
	logic ack_in_valid;
	logic [15:0] ack_in_xid;
	logic rx_valid;
	logic rx_first;
	logic rx_last;
	logic rx_class2;
	logic [15:0] rx_rxid;
	logic ack_out_valid;
	logic [15:0] ack_out_xid;
	logic ack_out_ack0;
	modport neg (output il_on, ack0_recip, own_xid, tx_valid, tx_first, tx_class2,
		ack_in_valid, ack_in_xid, rx_valid, rx_first, rx_last, rx_class2, rx_rxid,
		input tx_ready, tx_fire, tx_rxid, assigned_xid, il_wait, ack_out_valid,
		ack_out_xid, ack_out_ack0);
	modport eng (input il_on, ack0_recip, own_xid, tx_valid, tx_first, tx_class2,
		ack_in_valid, ack_in_xid, rx_valid, rx_first, rx_last, rx_class2, rx_rxid,
		output tx_ready, tx_fire, tx_rxid, assigned_xid, il_wait, ack_out_valid,
		ack_out_xid, ack_out_ack0);
endinterface
`default_nettype wire

// [logic/xid_interlock.sv]
`timescale 1ns/1ps
`default_nettype none
module xid_interlock
	import svc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	xid_if.eng fx
);
	// ==========================================================
	// initiator side
	il_state_t state_reg, state_next;
	logic tx_ready_reg, tx_fire_reg, ack_out_valid_reg, ack_out_ack0_reg;
	logic [15:0] tx_rxid_reg, assigned_reg, assigned_next, ack_out_xid_reg;
	wire logic take_tx = fx.tx_valid & tx_ready_reg;
	wire logic tx_locked = fx.il_on & fx.tx_class2 & fx.tx_first;
	wire logic [15:0] tx_rxid_next = fx.tx_first ? XID_UNASSIGNED : assigned_reg;
	wire logic rx_unassigned = (fx.rx_rxid == XID_UNASSIGNED);
	wire logic rx_lock_hit = fx.il_on & fx.rx_class2 & fx.rx_first & rx_unassigned;
	// ack_0 covers the whole sequence, so only the last frame (or the interlock one) is acked
	wire logic ack_sel = fx.ack0_recip ? (fx.rx_last | rx_lock_hit) : 1'b1;
	wire logic ack_due = fx.rx_valid & fx.rx_class2 & ack_sel;
	always_comb begin
		state_next = state_reg;
		assigned_next = assigned_reg;
		unique case (state_reg)
			IL_IDLE: begin
				if (take_tx && tx_locked) begin
					state_next = IL_WAIT;
				end
				if (fx.ack_in_valid && assigned_reg == XID_UNASSIGNED) begin
					assigned_next = fx.ack_in_xid;
				end
			end
			IL_WAIT: begin
				// login loss releases the hold so the sender cannot hang
				if (fx.ack_in_valid || !fx.il_on) begin
					state_next = IL_IDLE;
					assigned_next = fx.ack_in_valid ? fx.ack_in_xid : assigned_reg;
				end
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= IL_IDLE;
			assigned_reg <= XID_UNASSIGNED;
			tx_ready_reg <= 1'b1;
			tx_fire_reg <= 1'b0;
			tx_rxid_reg <= XID_UNASSIGNED;
		end else begin
			state_reg <= state_next;
			assigned_reg <= (take_tx && fx.tx_first) ? XID_UNASSIGNED : assigned_next;
			tx_ready_reg <= (state_next == IL_IDLE);
			tx_fire_reg <= take_tx;
			tx_rxid_reg <= take_tx ? tx_rxid_next : tx_rxid_reg;
		end
	end
	// ==========================================================
	// recipient side
	always_ff @(posedge clk) begin
		if (rst) begin
			ack_out_valid_reg <= 1'b0;
			ack_out_xid_reg <= XID_UNASSIGNED;
			ack_out_ack0_reg <= 1'b0;
		end else begin
			ack_out_valid_reg <= ack_due;
			ack_out_xid_reg <= ack_due ? fx.own_xid : ack_out_xid_reg;
			ack_out_ack0_reg <= ack_due ? fx.ack0_recip : ack_out_ack0_reg;
		end
	end
	assign fx.tx_ready = tx_ready_reg;
	assign fx.tx_fire = tx_fire_reg;
	assign fx.tx_rxid = tx_rxid_reg;
	assign fx.assigned_xid = assigned_reg;
	assign fx.il_wait = (state_reg == IL_WAIT);
	assign fx.ack_out_valid = ack_out_valid_reg;
	assign fx.ack_out_xid = ack_out_xid_reg;
	assign fx.ack_out_ack0 = ack_out_ack0_reg;
endmodule
`default_nettype wire

// [tb/svc_negotiate_properties.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// login outcome and frame checker
module svc_negotiate_properties
	import svc_pkg::*;
(
	input wire logic clk, rst, login_req_valid, acc_valid, logged_in, qos_usable,
	input wire logic [31:0] login_c2_w0, login_c3_w0, acc_w0, acc_w1,
	input wire logic [23:0] acc_src_id,
	input wire logic ack0_as_init, ack0_as_recip, ack_rx_enable, inf_buffering, interlock_on,
	input wire logic peer_clksync, tx_valid, tx_ready, tx_first, tx_class2, tx_fire,
	input wire logic [15:0] tx_rxid,
	input wire logic ack_in_valid, ack_out_valid, ack_out_ack0
);
	logic acc_q;
	logic [31:0] w0_q;
	logic [31:0] w1_q;
	logic [23:0] src_q;
	// accept copied one cycle on, where its outcome lands
	always_ff @(posedge clk) begin
		acc_q <= acc_valid;
		w0_q <= acc_w0;
		w1_q <= acc_w1;
		src_q <= acc_src_id;
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	AST_REQ_QOS: assert property (
		login_req_valid |-> login_c2_w0[W0_QOS] && login_c3_w0[W0_QOS])
		else $error("login request lacks qos bit");
	AST_QOS_AGREE: assert property (
		$rose(qos_usable) |-> acc_q && w0_q[W0_QOS])
		else $error("qos usable without accept bit");
	AST_ACK0_INIT: assert property (
		$rose(ack0_as_init) |-> acc_q && w1_q[W1_RECIP_ACK0] && ack_rx_enable)
		else $error("ack0 as initiator without both bits");
	AST_ACK0_RECIP: assert property (
		$rose(ack0_as_recip) |-> acc_q && w0_q[W0_INIT_ACK0] && inf_buffering)
		else $error("ack0 as recipient without both bits");
	AST_CLKSYNC: assert property (
		$rose(peer_clksync) |-> acc_q && w0_q[W0_CLKSYNC] && src_q == CLKSYNC_SERVER_ID)
		else $error("clock sync taken from wrong sender");
	AST_FIRST_RXID: assert property (
		tx_valid && tx_ready && tx_first |=> tx_fire && tx_rxid == XID_UNASSIGNED)
		else $error("first frame not sent with unassigned id");
	AST_IL_HOLD: assert property (
		interlock_on && tx_valid && tx_ready && tx_first && tx_class2 && !ack_in_valid |=> !tx_ready)
		else $error("interlocked first frame did not stall");
	AST_IL_RELEASE: assert property (
		!tx_ready && ack_in_valid |=> tx_ready)
		else $error("stall not released by ack");
	AST_ACK_FORM: assert property (
		ack_out_valid |-> ack_out_ack0 == $past(ack0_as_recip))
		else $error("ack form does not follow negotiation");
	AST_HOLD: assert property (
		logged_in && !acc_q |-> $stable(qos_usable) && $stable(interlock_on) && $stable(ack0_as_init))
		else $error("outcome moved without accept");
	cover property (ack_in_valid && !tx_ready);
	cover property (ack_out_valid && ack_out_ack0);
	cover property ($rose(peer_clksync));
endmodule
bind svc_negotiate svc_negotiate_properties i_props (.clk, .rst, .login_req_valid, .acc_valid,
	.logged_in, .qos_usable, .login_c2_w0, .login_c3_w0, .acc_w0, .acc_w1, .acc_src_id,
	.ack0_as_init, .ack0_as_recip, .ack_rx_enable, .inf_buffering, .interlock_on, .peer_clksync,
	.tx_valid, .tx_ready, .tx_first, .tx_class2, .tx_fire, .tx_rxid, .ack_in_valid,
	.ack_out_valid, .ack_out_ack0);
`default_nettype wire

// [tb/peer_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// far side: fabric controller and sequence recipient
module peer_model
	import svc_pkg::*;
#(
	parameter logic [15:0] PEER_XID = 16'h0A5C
)
(
	input wire logic clk, rst, login_req_valid, tx_fire, tx_class2,
	input wire logic [15:0] tx_rxid,
	input wire logic [31:0] p_w0, p_w1,
	input wire logic [23:0] p_src,
	input wire logic [3:0] p_lat,
	output logic acc_valid, ack_in_valid,
	output logic [31:0] acc_w0, acc_w1,
	output logic [23:0] acc_src_id,
	output logic [15:0] ack_in_xid
);
	logic [3:0] acc_cnt;
	logic [3:0] ack_cnt;
	always_ff @(posedge clk) begin
		if (rst) begin
			acc_cnt <= 4'h0;
			ack_cnt <= 4'h0;
		end else begin
			acc_cnt <= login_req_valid ? p_lat : acc_cnt - {3'h0, acc_cnt != 4'h0};
			// class 3 is unacknowledged, so only class 2 first frames get an ack
			ack_cnt <= (tx_fire && tx_class2 && tx_rxid == XID_UNASSIGNED) ? 4'h3 :
				ack_cnt - {3'h0, ack_cnt != 4'h0};
		end
	end
	// words invert outside the strobe so a late sample never sees stale data
	assign acc_valid = acc_cnt == 4'h1;
	assign acc_w0 = acc_valid ? p_w0 : ~p_w0;
	assign acc_w1 = acc_valid ? p_w1 : ~p_w1;
	assign acc_src_id = acc_valid ? p_src : ~p_src;
	assign ack_in_valid = ack_cnt == 4'h1;
	assign ack_in_xid = ack_in_valid ? PEER_XID : ~PEER_XID;
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// stimulus and signals
module testbench import svc_pkg::*; ;
	localparam logic [15:0] PEER_XID = 16'h0A5C;
	localparam logic [15:0] OWN_XID = 16'hBEEF;
	logic clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, login_start = 1'b0;
	logic login_fabric = 1'b0, logout = 1'b0, acc_reject = 1'b0, tx_valid = 1'b0;
	logic tx_first = 1'b0, tx_class2 = 1'b0, rx_valid = 1'b0, rx_first = 1'b0;
	logic rx_last = 1'b0, rx_class2 = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [15:0] rx_rxid = 16'h0000;
	logic [31:0] wr_data = 32'h0, p_w0 = 32'h0, p_w1 = 32'h0;
	logic [23:0] p_src = 24'h0;
	logic [3:0] p_lat = 4'h1;
	logic [31:0] rd_data, login_c2_w0, login_c3_w0, login_w1, acc_w0, acc_w1;
	logic [23:0] acc_src_id;
	logic [15:0] tx_rxid, ack_in_xid, ack_out_xid;
	logic login_req_valid, acc_valid, logged_in, qos_usable, ack0_as_init, ack0_as_recip;
	logic ack_rx_enable, inf_buffering, interlock_on, peer_ack_assist, peer_clksync;
	logic tx_ready, tx_fire, ack_in_valid, ack_out_valid, ack_out_ack0;
	int miscompares = 0, checks_done = 0;
	always #50 clk = ~clk;
	svc_negotiate i_dut (.clk, .rst, .addr, .wr_data, .wr_en, .rd_en, .rd_data, .login_start,
		.login_fabric, .logout, .login_req_valid, .login_c2_w0, .login_c3_w0, .login_w1,
		.acc_valid, .acc_reject, .acc_w0, .acc_w1, .acc_src_id, .logged_in, .qos_usable,
		.ack0_as_init, .ack0_as_recip, .ack_rx_enable, .inf_buffering, .interlock_on,
		.peer_ack_assist, .peer_clksync, .tx_valid, .tx_first, .tx_class2, .tx_ready, .tx_fire,
		.tx_rxid, .ack_in_valid, .ack_in_xid, .rx_valid, .rx_first, .rx_last, .rx_class2,
		.rx_rxid, .ack_out_valid, .ack_out_xid, .ack_out_ack0);
	peer_model #(.PEER_XID(PEER_XID)) i_peer (.clk, .rst, .login_req_valid, .tx_fire, .tx_class2,
		.tx_rxid,
		.p_w0, .p_w1, .p_src, .p_lat, .acc_valid, .ack_in_valid, .acc_w0, .acc_w1, .acc_src_id,
		.ack_in_xid);
	// ==========================================
	// shared tasks
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic timeout();
		miscompares++;
		end_sim();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 d = rd_data;
	endtask
	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [31:0] d;
		rd(OFS_CFG, d);
		chk("cfg", d, {25'h0, CFG_RESET});
		rd(OFS_STATUS, d);
		chk("status", d, 32'h0);
		rd(8'h3C, d);
		chk("unmapped", d, 32'h0);
		rd(OFS_ASSIGNED, d);
		chk("assigned", d, {16'h0, XID_UNASSIGNED});
		wr(OFS_XID, {16'h0, OWN_XID});
	endtask
	// passes 1 to 3 mix own and peer bits so the two ack0 roles differ
	task automatic t_login(input logic [1:0] i);
		logic [31:0] d;
		int n;
		wr(OFS_CFG, {25'h0, CFG_RESET | {3'b0, i[1], 1'b0, i}});
		p_w0 <= {1'b1, 9'h0, i[0], 9'h0, i[0] ^ i[1], 1'b0, i[0], 4'h0, 1'b1, 4'h0};
		p_w1 <= 32'h80000000;
		p_src <= i[1] ? CLKSYNC_SERVER_ID : 24'h010203;
		p_lat <= 4'h1 + {i, 1'b0};
		@(posedge clk);
		login_start <= 1'b1;
		login_fabric <= 1'b1;
		@(posedge clk);
		login_start <= 1'b0;
		n = 0;
		#1;
		while (login_req_valid !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 20) timeout();
		chk("req qos", {login_c2_w0[W0_QOS], login_c3_w0[W0_QOS]}, 2'b11);
		chk("req bits", {login_c2_w0[W0_INIT_ACK0], login_w1[W1_RECIP_ACK0]}, {i[0], i[1]});
		chk("old qos", qos_usable, i != 2'd0 && !i[0]);
		repeat (p_lat + 2) @(posedge clk);
		#1;
		chk("qos", {logged_in, qos_usable}, {1'b1, i[0]});
		chk("ack0", {ack0_as_init, ack0_as_recip, ack_rx_enable, inf_buffering},
			{i[0], i == 2'd2, i[0], i[1]});
		chk("peer", {peer_ack_assist, peer_clksync, interlock_on},
			{i[0], i[1], i[1]});
		rd(OFS_STATUS, d);
		chk("qos case", d[1:0], {1'b1, i[0]});
	endtask
	task automatic rx_frame(input logic c2, input logic first, input logic last,
		input logic exp_ack, input logic a0);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_class2 <= c2;
		rx_first <= first;
		rx_rxid <= {16{first}};
		rx_last <= last;
		@(posedge clk);
		rx_valid <= 1'b0;
		#1;
		chk("ack out", ack_out_valid, exp_ack);
		if (exp_ack) chk("ack form", {ack_out_ack0, ack_out_xid}, {a0, OWN_XID});
	endtask
	task automatic t_ack(input logic a0);
		rx_frame(1'b1, 1'b1, 1'b0, 1'b1, a0);
		rx_frame(1'b1, 1'b0, 1'b0, !a0, a0);
		rx_frame(1'b1, 1'b0, 1'b1, 1'b1, a0);
		rx_frame(1'b0, 1'b0, 1'b1, 1'b0, a0);
	endtask
	task automatic t_frames();
		logic [31:0] d;
		int n;
		@(posedge clk);
		tx_valid <= 1'b1;
		tx_first <= 1'b1;
		@(posedge clk);
		tx_valid <= 1'b0;
		#1;
		chk("c3 first", {tx_fire, tx_ready, tx_rxid}, {2'b11, XID_UNASSIGNED});
		repeat (6) @(posedge clk);
		tx_valid <= 1'b1;
		tx_class2 <= 1'b1;
		@(posedge clk);
		tx_first <= 1'b0;
		#1;
		chk("il first", {tx_fire, tx_ready, tx_rxid}, {2'b10, XID_UNASSIGNED});
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (tx_fire !== 1'b1 && n < 20);
		tx_valid <= 1'b0;
		if (n == 20) timeout();
		chk("il resume", {n[3:0], tx_rxid}, {4'd5, PEER_XID});
		rd(OFS_ASSIGNED, d);
		chk("assigned", d, {16'h0, PEER_XID});
	endtask
	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		for (int i = 0; i < 4; i++) begin
			t_login(i[1:0]);
			if (i == 2) t_ack(1'b1);
		end
		t_frames();
		t_ack(1'b0);
		@(posedge clk);
		logout <= 1'b1;
		@(posedge clk);
		logout <= 1'b0;
		@(posedge clk);
		#1;
		chk("logout", {logged_in, qos_usable, interlock_on}, 3'b000);
		end_sim();
	end
endmodule
`default_nettype wire
